// >>> cbtim_defines.svh
/*
 Constants of the CAN bit timing block: offsets, fields, resets.
 Assumes inclusion by bare name from the block's design file.
*/
`ifndef CBTIM_DEFINES_SVH
`define CBTIM_DEFINES_SVH
`define CBTIM_OFS_PRESCALE_JUMP 8'h00
`define CBTIM_OFS_SEGMENTS      8'h04
`define CBTIM_OFS_PHASE_TWO     8'h08
`define CBTIM_OFS_CONTROL       8'h0C
`define CBTIM_OFS_STATUS        8'h10
`define CBTIM_PRESC_LSB         0
`define CBTIM_PRESC_MSB         5
`define CBTIM_JUMP_LSB          6
`define CBTIM_JUMP_MSB          7
`define CBTIM_PROP_LSB          0
`define CBTIM_PROP_MSB          2
`define CBTIM_PH1_LSB           3
`define CBTIM_PH1_MSB           5
`define CBTIM_TRIPLE_BIT        6
`define CBTIM_PH2SRC_BIT        7
`define CBTIM_PH2_LSB           0
`define CBTIM_PH2_MSB           2
`define CBTIM_CFG_MODE_BIT      0
`define CBTIM_RST_PRESCALE_JUMP 8'h00
`define CBTIM_RST_SEGMENTS      8'h00
`define CBTIM_RST_PHASE_TWO     8'h00
`define CBTIM_RST_CFG_MODE      1'b1
`define CBTIM_PROC_TQ           5'h02
`define CBTIM_RESP_OKAY         2'h0
`define CBTIM_RESP_SLVERR       2'h2
`endif

// >>> cbtim_pkg.sv
/*
 Types of the CAN bit timing block.
 Assumes nothing of its surroundings.
*/
package cbtim_pkg;
  typedef enum logic [3:0] {
    ST_SYNC = 4'h1,
    ST_PROP = 4'h2,
    ST_PH1  = 4'h4,
    ST_PH2  = 4'h8
  } cbtim_seg_e;
endpackage

// >>> cbtim_core.sv
/*
 CAN bit timing and synchronisation with an AXI4-Lite register slave.
 Assumes one 125 MHz clock, the receive pin asynchronous to it, and a
 protocol engine on the same clock supplying the bit to send and idle.
*/
`timescale 1ns/1ns
`include "cbtim_defines.svh"
module cbtim_core (
  // Clock and reset
  input  wire logic        I_CORE_CLK,
  input  wire logic        I_RSTN,
  // AXI4-Lite write address
  input  wire logic [7:0]  I_AWADDR,
  input  wire logic        I_AWVALID,
  output logic             O_AWREADY,
  // AXI4-Lite write data
  input  wire logic [31:0] I_WDATA,
  input  wire logic [3:0]  I_WSTRB,
  input  wire logic        I_WVALID,
  output logic             O_WREADY,
  // AXI4-Lite write response
  output logic [1:0]       O_BRESP,
  output logic             O_BVALID,
  input  wire logic        I_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  I_ARADDR,
  input  wire logic        I_ARVALID,
  output logic             O_ARREADY,
  output logic [31:0]      O_RDATA,
  output logic [1:0]       O_RRESP,
  output logic             O_RVALID,
  input  wire logic        I_RREADY,
  // Protocol engine
  input  wire logic        I_TX_BIT,
  input  wire logic        I_BUS_IDLE,
  output logic             O_RX_BIT,
  output logic             O_SAMPLE_STB,
  output logic             O_BIT_START,
  // CAN pins, 1 is recessive
  input  wire logic        I_BUS_RECEIVE_PIN,
  output logic             O_BUS_TRANSMIT_PIN
);

  // Register file.
  logic [7:0] presc_jump_reg;
  logic [7:0] segments_reg;
  logic [7:0] phase_two_reg;
  logic       cfg_mode_reg;

  // Bus slave state.
  logic        awready_reg;
  logic        wready_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;
  logic [7:0]  awaddr_reg;
  logic [7:0]  wdata_reg;
  logic        wstrb0_reg;
  logic        arready_reg;
  logic        rvalid_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rdata_reg;

  // Bit timing state.
  logic [1:0]  rx_meta_reg;
  logic        rx_prev_reg;
  logic [5:0]  presc_cnt_reg;
  logic        half_ph_reg;
  logic [1:0]  half_smp_reg;
  cbtim_pkg::cbtim_seg_e seg_reg;
  logic [4:0]  tq_cnt_reg;
  logic [4:0]  ph1_ext_reg;
  logic [4:0]  ph2_cut_reg;
  logic        synced_reg;
  logic        rx_bit_reg;
  logic        smp_stb_reg;
  logic        bit_start_reg;
  logic        tx_pin_reg;

  // Field decode.
  wire [5:0] presc   = presc_jump_reg[`CBTIM_PRESC_MSB:`CBTIM_PRESC_LSB];
  wire [4:0] jump_tq = {3'h0, presc_jump_reg[`CBTIM_JUMP_MSB:`CBTIM_JUMP_LSB]}
                       + 5'h01;
  wire [4:0] prop_tq = {2'h0, segments_reg[`CBTIM_PROP_MSB:`CBTIM_PROP_LSB]}
                       + 5'h01;
  wire [4:0] ph1_tq  = {2'h0, segments_reg[`CBTIM_PH1_MSB:`CBTIM_PH1_LSB]}
                       + 5'h01;
  wire       triple  = segments_reg[`CBTIM_TRIPLE_BIT];
  wire       ph2_src = segments_reg[`CBTIM_PH2SRC_BIT];
  wire [4:0] ph2_reg_tq = {2'h0, phase_two_reg[`CBTIM_PH2_MSB:`CBTIM_PH2_LSB]}
                          + 5'h01;
  // Phase 2 is clamped to at least the processing time here, but a resync
  // cut can still shorten it to one quantum before the following sync segment.
  wire [4:0] ph2_auto = (ph1_tq > `CBTIM_PROC_TQ) ? ph1_tq
                        : `CBTIM_PROC_TQ;
  wire [4:0] ph2_sel  = ph2_src ? ph2_reg_tq : ph2_auto;
  wire [4:0] ph2_tq   = (ph2_sel < `CBTIM_PROC_TQ) ? `CBTIM_PROC_TQ
                        : ph2_sel;

  // Quantum generation: a half-quantum every prescaler+1 clocks.
  wire half_tick = (presc_cnt_reg == presc);
  wire tq_tick   = half_tick & half_ph_reg;

  // Receive edge, read from the second synchroniser stage only.
  wire rx_s      = rx_meta_reg[1];
  wire fall_edge = rx_prev_reg & ~rx_s;

  // Segment end points, adjusted by resynchronisation.
  wire [4:0] ph1_len = ph1_tq + ph1_ext_reg;
  wire [4:0] ph2_len = (ph2_tq > ph2_cut_reg) ?
                       (ph2_tq - ph2_cut_reg) : 5'h01;
  wire seg_last = (seg_reg == cbtim_pkg::ST_SYNC) ? 1'b1 :
                  (seg_reg == cbtim_pkg::ST_PROP) ?
                  (tq_cnt_reg == prop_tq - 5'h01) :
                  (seg_reg == cbtim_pkg::ST_PH1) ?
                  (tq_cnt_reg == ph1_len - 5'h01) :
                  (tq_cnt_reg == ph2_len - 5'h01);
  wire seg_end  = tq_tick & seg_last;
  wire smp_pt   = seg_end & (seg_reg == cbtim_pkg::ST_PH1);

  // Majority of the sample point and the two half-quanta before it.
  wire vote = (rx_s & half_smp_reg[0]) | (rx_s & half_smp_reg[1]) |
              (half_smp_reg[0] & half_smp_reg[1]);
  wire smp_val = triple ? vote : rx_s;

  // Phase error in quanta, positive before the sample point.
  wire in_pos  = (seg_reg == cbtim_pkg::ST_PROP) |
                 (seg_reg == cbtim_pkg::ST_PH1);
  wire [4:0] err_pos = (seg_reg == cbtim_pkg::ST_PROP) ?
                       (tq_cnt_reg + 5'h01) :
                       (prop_tq + tq_cnt_reg + 5'h01);
  wire [4:0] err_neg = ph2_len - tq_cnt_reg;
  wire in_neg  = (seg_reg == cbtim_pkg::ST_PH2);

  // Edge qualification.
  wire edge_ok = fall_edge & ~synced_reg & rx_bit_reg
                 & ~cfg_mode_reg;
  wire hard_sync = edge_ok & I_BUS_IDLE;
  wire pos_ok  = in_pos & ~(tx_pin_reg == 1'b0);
  wire re_pos  = edge_ok & ~I_BUS_IDLE & pos_ok;
  wire re_neg  = edge_ok & ~I_BUS_IDLE & in_neg;
  wire small_pos = re_pos & (err_pos <= jump_tq);
  wire small_neg = re_neg & (err_neg <= jump_tq);
  wire big_pos = re_pos & (err_pos > jump_tq);
  wire big_neg = re_neg & (err_neg > jump_tq);
  // A resync edge within the jump width restarts the bit just like a hard sync.
  wire restart = hard_sync | small_pos | small_neg;
  wire synced_now = restart | big_pos | big_neg;

  // Register decode.
  wire wr_go = ~awready_reg & ~wready_reg & ~bvalid_reg;
  wire wr_timing = (awaddr_reg == `CBTIM_OFS_PRESCALE_JUMP) |
                   (awaddr_reg == `CBTIM_OFS_SEGMENTS) |
                   (awaddr_reg == `CBTIM_OFS_PHASE_TWO);
  wire wr_mapped = wr_timing |
                   (awaddr_reg == `CBTIM_OFS_CONTROL) |
                   (awaddr_reg == `CBTIM_OFS_STATUS);
  wire wr_en     = wr_go & wstrb0_reg;
  // Timing fields are frozen while the bit engine runs.
  wire wr_cfg_ok = wr_en & cfg_mode_reg;
  wire [31:0] status_word = {25'h0000000, synced_reg, seg_reg,
                             tx_pin_reg, rx_bit_reg};
  wire [31:0] rd_word =
    (I_ARADDR == `CBTIM_OFS_PRESCALE_JUMP) ? {24'h000000, presc_jump_reg} :
    (I_ARADDR == `CBTIM_OFS_SEGMENTS)      ? {24'h000000, segments_reg} :
    (I_ARADDR == `CBTIM_OFS_PHASE_TWO)     ? {24'h000000, phase_two_reg} :
    (I_ARADDR == `CBTIM_OFS_CONTROL)       ? {31'h00000000, cfg_mode_reg} :
    (I_ARADDR == `CBTIM_OFS_STATUS)        ? status_word : 32'h00000000;
  wire rd_mapped = (I_ARADDR == `CBTIM_OFS_PRESCALE_JUMP) |
                   (I_ARADDR == `CBTIM_OFS_SEGMENTS) |
                   (I_ARADDR == `CBTIM_OFS_PHASE_TWO) |
                   (I_ARADDR == `CBTIM_OFS_CONTROL) |
                   (I_ARADDR == `CBTIM_OFS_STATUS);

  // Write channels are taken in either order, then answered together.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `CBTIM_RESP_OKAY;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 8'h00;
      wstrb0_reg  <= 1'b0;
    end else begin
      if (awready_reg & I_AWVALID) begin
        awready_reg <= 1'b0;
        awaddr_reg  <= I_AWADDR;
      end
      if (wready_reg & I_WVALID) begin
        wready_reg <= 1'b0;
        wdata_reg  <= I_WDATA[7:0];
        wstrb0_reg <= I_WSTRB[0];
      end
      if (wr_go) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_mapped ? `CBTIM_RESP_OKAY : `CBTIM_RESP_SLVERR;
      end
      if (bvalid_reg & I_BREADY) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Register storage.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      presc_jump_reg <= `CBTIM_RST_PRESCALE_JUMP;
      segments_reg   <= `CBTIM_RST_SEGMENTS;
      phase_two_reg  <= `CBTIM_RST_PHASE_TWO;
      cfg_mode_reg   <= `CBTIM_RST_CFG_MODE;
    end else begin
      if (wr_cfg_ok & (awaddr_reg == `CBTIM_OFS_PRESCALE_JUMP)) begin
        presc_jump_reg <= wdata_reg;
      end
      if (wr_cfg_ok & (awaddr_reg == `CBTIM_OFS_SEGMENTS)) begin
        segments_reg <= wdata_reg;
      end
      if (wr_cfg_ok & (awaddr_reg == `CBTIM_OFS_PHASE_TWO)) begin
        phase_two_reg <= wdata_reg;
      end
      if (wr_en & (awaddr_reg == `CBTIM_OFS_CONTROL)) begin
        cfg_mode_reg <= wdata_reg[`CBTIM_CFG_MODE_BIT];
      end
    end
  end

  // Read channel, one read under way at a time.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `CBTIM_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else if (arready_reg & I_ARVALID) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b1;
      rdata_reg   <= rd_word;
      rresp_reg   <= rd_mapped ? `CBTIM_RESP_OKAY : `CBTIM_RESP_SLVERR;
    end else if (rvalid_reg & I_RREADY) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
    end
  end

  // Pin synchroniser and edge history.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_meta_reg <= 2'h3;
      rx_prev_reg <= 1'b1;
    end else begin
      rx_meta_reg <= {rx_meta_reg[0], I_BUS_RECEIVE_PIN};
      rx_prev_reg <= rx_s;
    end
  end

  // Prescaler; a restart realigns the quantum grid to the edge.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      presc_cnt_reg <= 6'h00;
      half_ph_reg   <= 1'b0;
      half_smp_reg  <= 2'h3;
    end else if (cfg_mode_reg | restart) begin
      presc_cnt_reg <= 6'h00;
      half_ph_reg   <= 1'b0;
    end else if (half_tick) begin
      presc_cnt_reg <= 6'h00;
      half_ph_reg   <= ~half_ph_reg;
      half_smp_reg  <= {half_smp_reg[0], rx_s};
    end else begin
      presc_cnt_reg <= presc_cnt_reg + 6'h01;
    end
  end

  // Segment sequencer; a restart puts the edge inside sync.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      seg_reg     <= cbtim_pkg::ST_SYNC;
      tq_cnt_reg  <= 5'h00;
      ph1_ext_reg <= 5'h00;
      ph2_cut_reg <= 5'h00;
      synced_reg  <= 1'b0;
    end else if (cfg_mode_reg) begin
      seg_reg     <= cbtim_pkg::ST_SYNC;
      tq_cnt_reg  <= 5'h00;
      ph1_ext_reg <= 5'h00;
      ph2_cut_reg <= 5'h00;
      synced_reg  <= 1'b0;
    end else if (restart) begin
      seg_reg     <= cbtim_pkg::ST_SYNC;
      tq_cnt_reg  <= 5'h00;
      ph1_ext_reg <= 5'h00;
      ph2_cut_reg <= 5'h00;
      synced_reg  <= 1'b1;
    end else begin
      if (big_pos) begin
        ph1_ext_reg <= jump_tq;
        synced_reg  <= 1'b1;
      end
      if (big_neg) begin
        ph2_cut_reg <= jump_tq;
        synced_reg  <= 1'b1;
      end
      if (seg_end) begin
        tq_cnt_reg <= 5'h00;
        case (seg_reg)
          cbtim_pkg::ST_SYNC: begin
            seg_reg <= cbtim_pkg::ST_PROP;
          end
          cbtim_pkg::ST_PROP: begin
            seg_reg <= cbtim_pkg::ST_PH1;
          end
          cbtim_pkg::ST_PH1: begin
            seg_reg <= cbtim_pkg::ST_PH2;
          end
          cbtim_pkg::ST_PH2: begin
            seg_reg     <= cbtim_pkg::ST_SYNC;
            ph1_ext_reg <= 5'h00;
            ph2_cut_reg <= 5'h00;
            synced_reg  <= 1'b0;
          end
          default: begin
            seg_reg <= cbtim_pkg::ST_SYNC;
          end
        endcase
      end else if (tq_tick) begin
        tq_cnt_reg <= tq_cnt_reg + 5'h01;
      end
    end
  end

  // Engine-facing outputs and the transmit pin.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rx_bit_reg    <= 1'b1;
      smp_stb_reg   <= 1'b0;
      bit_start_reg <= 1'b0;
      tx_pin_reg    <= 1'b1;
    end else begin
      smp_stb_reg   <= smp_pt & ~cfg_mode_reg;
      bit_start_reg <= 1'b0;
      if (cfg_mode_reg) begin
        tx_pin_reg <= 1'b1;
      end else if (smp_pt) begin
        rx_bit_reg <= smp_val;
      end
      if (~cfg_mode_reg & ((seg_end & (seg_reg == cbtim_pkg::ST_PH2))
                           | restart)) begin
        tx_pin_reg    <= I_TX_BIT;
        bit_start_reg <= 1'b1;
      end
    end
  end

  // Output drive, all from flip-flops.
  assign O_AWREADY          = awready_reg;
  assign O_WREADY           = wready_reg;
  assign O_BVALID           = bvalid_reg;
  assign O_BRESP            = bresp_reg;
  assign O_ARREADY          = arready_reg;
  assign O_RVALID           = rvalid_reg;
  assign O_RRESP            = rresp_reg;
  assign O_RDATA            = rdata_reg;
  assign O_RX_BIT           = rx_bit_reg;
  assign O_SAMPLE_STB       = smp_stb_reg;
  assign O_BIT_START        = bit_start_reg;
  assign O_BUS_TRANSMIT_PIN = tx_pin_reg;

endmodule

// >>> cbtim_monitor.sv
/*
 Port checker for the CAN bit timing block.
 Assumes it is bound to cbtim_core, one clock domain.
*/
`timescale 1ns/1ns
`include "cbtim_defines.svh"
module cbtim_monitor (
  // Clock and reset
  input wire logic        I_CORE_CLK,
  input wire logic        I_RSTN,
  // Register bus
  input wire logic        I_AWVALID,
  input wire logic        O_AWREADY,
  input wire logic        O_WREADY,
  input wire logic [1:0]  O_BRESP,
  input wire logic        O_BVALID,
  input wire logic        I_BREADY,
  input wire logic [7:0]  I_ARADDR,
  input wire logic        I_ARVALID,
  input wire logic        O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic [1:0]  O_RRESP,
  input wire logic        O_RVALID,
  input wire logic        I_RREADY,
  // Bit engine
  input wire logic        O_RX_BIT,
  input wire logic        O_SAMPLE_STB,
  input wire logic        O_BIT_START,
  input wire logic        O_BUS_TRANSMIT_PIN
);
  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);
  property p_tx_at_start;
    $changed(O_BUS_TRANSMIT_PIN) |-> O_BIT_START;
  endproperty
  a_tx_at_start: assert property (p_tx_at_start) else $error("tx pin moved off bit start");
  property p_rx_at_smp;
    $changed(O_RX_BIT) |-> O_SAMPLE_STB;
  endproperty
  a_rx_at_smp: assert property (p_rx_at_smp) else $error("rx bit moved without strobe");
  property p_start_pulse;
    O_BIT_START |=> !O_BIT_START;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("bit start too long");
  property p_smp_gap;
    O_SAMPLE_STB |=> !O_SAMPLE_STB [*3];
  endproperty
  a_smp_gap: assert property (p_smp_gap) else $error("samples too close");
  property p_r_ans;
    I_ARVALID && O_ARREADY |=> O_RVALID && !O_ARREADY;
  endproperty
  a_r_ans: assert property (p_r_ans) else $error("read answer late");
  property p_r_hold;
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_r_unmapped;
    I_ARVALID && O_ARREADY && I_ARADDR > 8'h10 |=> O_RRESP == `CBTIM_RESP_SLVERR && O_RDATA == 32'h0;
  endproperty
  a_r_unmapped: assert property (p_r_unmapped) else $error("unmapped read not refused");
  property p_b_hold;
    O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_b_busy;
    O_BVALID |-> !O_AWREADY && !O_WREADY;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("write taken while busy");
  c_start: cover property (O_BIT_START);
  c_dom: cover property (O_SAMPLE_STB && !O_RX_BIT);
  c_err: cover property (O_BVALID && O_BRESP == `CBTIM_RESP_SLVERR);
endmodule
bind cbtim_core cbtim_monitor mon (.*);

// >>> cbtim_node.sv
/*
 Model of another CAN node on the bus.
 Assumes a wired-AND bus with a recessive pull-up.
*/
`timescale 1ns/1ns
module cbtim_node (
  // Bus
  input  wire logic i_tx_pin,
  output logic      o_rx_pin
);
  logic lvl = 1'b1;
  // Dominant wins, so the block's receive pin sees the AND of the two levels.
  assign o_rx_pin = lvl & i_tx_pin;
  // Bit period is free, so a node on a drifting clock can be imitated.
  task automatic send(input logic [7:0] bits, input int per);
    for (int i = 7; i >= 0; i--) begin
      lvl = bits[i];
      #per;
    end
    lvl = 1'b1;
  endtask
endmodule

// >>> tb.sv
/*
 Self-checking bench for the CAN bit timing block.
 Assumes the design, its defines and the node model.
*/
`timescale 1ns/1ns
`include "cbtim_defines.svh"
module tb;
  logic        clk, rstn, awv, wv, bry, arv, rry, txb, idle;
  logic        rxp, rxb, smp, bst, txp, awr, wr_, bv, arr, rv;
  logic [7:0]  awa, ara;
  logic [31:0] wd, rdat;
  logic [1:0]  bresp, rresp;
  int          n_fail, samples_checked;
  cbtim_core uut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_AWADDR(awa), .I_AWVALID(awv), .O_AWREADY(awr),
    .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr_), .O_BRESP(bresp), .O_BVALID(bv),
    .I_BREADY(bry), .I_ARADDR(ara), .I_ARVALID(arv), .O_ARREADY(arr), .O_RDATA(rdat), .O_RRESP(rresp),
    .O_RVALID(rv), .I_RREADY(rry), .I_TX_BIT(txb), .I_BUS_IDLE(idle), .O_RX_BIT(rxb),
    .O_SAMPLE_STB(smp), .O_BIT_START(bst), .I_BUS_RECEIVE_PIN(rxp), .O_BUS_TRANSMIT_PIN(txp));
  cbtim_node node (.i_tx_pin(txp), .o_rx_pin(rxp));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic finish_test;
    $display("checked %0d failed %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stall;
    check(32'h0, 32'h1);
    finish_test();
  endtask
  task automatic wchk(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    // Ready rises only once valid is seen, so the slave must hold its answer.
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_) wv <= 1'b0;
      if (bv && bry) break;
      if (bv) bry <= 1'b1;
    end
    if (k == 64) stall();
    bry <= 1'b0;
    check(bresp, er);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    int k;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    for (k = 0; k < 64; k++) begin
      @(posedge clk);
      if (arv && arr) arv <= 1'b0;
      if (rv && rry) break;
      if (rv) rry <= 1'b1;
    end
    if (k == 64) stall();
    rry <= 1'b0;
    check(rdat, {24'h0, ed});
    check(rresp, er);
  endtask
  // Counts edges up to the next strobe or bit start; n is the distance.
  task automatic wait_ev(input bit want_smp, output int n);
    for (n = 1; n < 2000; n++) begin
      @(posedge clk);
      if (want_smp ? smp : bst) return;
    end
    stall();
  endtask
  task automatic cfg(input logic [7:0] pj, input logic [7:0] sg, input logic [7:0] p2);
    wchk(`CBTIM_OFS_CONTROL, 8'h01, `CBTIM_RESP_OKAY);
    wchk(`CBTIM_OFS_PRESCALE_JUMP, pj, `CBTIM_RESP_OKAY);
    wchk(`CBTIM_OFS_SEGMENTS, sg, `CBTIM_RESP_OKAY);
    wchk(`CBTIM_OFS_PHASE_TWO, p2, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_SEGMENTS, sg, `CBTIM_RESP_OKAY);
    wchk(`CBTIM_OFS_CONTROL, 8'h00, `CBTIM_RESP_OKAY);
  endtask
  task automatic t_regs;
    rchk(`CBTIM_OFS_PRESCALE_JUMP, 8'h00, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_SEGMENTS, 8'h00, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_PHASE_TWO, 8'h00, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_CONTROL, 8'h01, `CBTIM_RESP_OKAY);
    wchk(8'h14, 8'hFF, `CBTIM_RESP_SLVERR);
    rchk(8'h14, 8'h00, `CBTIM_RESP_SLVERR);
  endtask
  // Bit lengths in clocks: quanta per bit times two times prescaler plus one.
  task automatic t_periods;
    logic [7:0] pj[7] = '{8'h00, 8'h01, 8'h02, 8'h00, 8'h00, 8'h00, 8'h3F};
    logic [7:0] sg[7] = '{8'h00, 8'h91, 8'h18, 8'hBF, 8'h08, 8'h80, 8'h00};
    logic [7:0] p2[7] = '{8'h00, 8'h02, 8'h00, 8'h07, 8'h07, 8'h00, 8'h00};
    int per[7] = '{10, 36, 60, 50, 12, 10, 640};
    int n;
    for (int i = 0; i < 7; i++) begin
      cfg(pj[i], sg[i], p2[i]);
      wait_ev(0, n);
      wait_ev(0, n);
      check(n, per[i]);
    end
    wchk(`CBTIM_OFS_SEGMENTS, 8'h55, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_SEGMENTS, 8'h00, `CBTIM_RESP_OKAY);
  endtask
  // Eight quanta of 16 ns per bit; the other node runs 6 percent slow.
  task automatic t_sync;
    logic [7:0] bits = 8'b0110_0101;
    int n;
    cfg(8'h00, 8'hD0, 8'h02);
    wait_ev(0, n);
    #3;
    fork
      node.send(bits, 136);
    join_none
    wait_ev(0, n);
    check(n <= 8, 1);
    idle <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      wait_ev(1, n);
      check(rxb, bits[i]);
    end
  endtask
  // A node 16 percent slow puts the second falling edge two quanta late.
  task automatic t_jump;
    int n;
    idle <= 1'b1;
    wait_ev(0, n);
    #3;
    fork
      node.send(8'b0101_1111, 148);
    join_none
    wait_ev(0, n);
    check(n <= 8, 1);
    idle <= 1'b0;
    wait_ev(0, n);
    wait_ev(0, n);
    wait_ev(1, n);
    check(n, 12);
  endtask
  // The first bit waited for samples recessive, so only the dominant send blocks the resync.
  task automatic t_tx;
    int n;
    wait_ev(0, n);
    txb <= 1'b0;
    wait_ev(0, n);
    wait_ev(0, n);
    check(n, 16);
    check(txp, 1'b0);
    txb <= 1'b1;
    wait_ev(0, n);
    wait_ev(0, n);
    check(txp, 1'b1);
  endtask
  // Reset in mid-run returns the engine to held configuration mode.
  task automatic t_reset;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    rchk(`CBTIM_OFS_CONTROL, 8'h01, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_STATUS, 8'h07, `CBTIM_RESP_OKAY);
    rchk(`CBTIM_OFS_PRESCALE_JUMP, 8'h00, `CBTIM_RESP_OKAY);
  endtask
  initial begin
    {rstn, awv, wv, bry, arv, rry} = '0;
    {awa, ara, wd} = '0;
    txb = 1'b1;
    idle = 1'b1;
    n_fail = 0;
    samples_checked = 0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_periods();
    t_sync();
    t_jump();
    t_tx();
    t_reset();
    finish_test();
  end
endmodule
